//--- inc/crl_regs.svh
/*
 * Constants of the calibration register loader: memory map, lock codes, timing.
 * Assumes nothing; included by bare name wherever a constant is needed.
 */
`ifndef CRL_REGS_SVH
`define CRL_REGS_SVH

// memory geometry
`define CRL_MEM_BYTES       768
`define CRL_PAGE_BYTES      64
`define CRL_PAGE_COUNT      12
`define CRL_ADDR_W          10
`define CRL_PAGE_W          4
`define CRL_PAGE_OFS_W      6

// fixed word locations (low byte address)
`define CRL_ADDR_CONFIG     10'h160
`define CRL_ADDR_OFFSET_TC  10'h164
`define CRL_ADDR_SPAN_TC    10'h168
`define CRL_ADDR_CONTROL    10'h16A

// lookup tables
`define CRL_OFFSET_LUT_BASE 10'h000
`define CRL_SPAN_LUT_BASE   10'h200
`define CRL_SPAN_LUT_BASE2  10'h1A0
`define CRL_SPAN_SPLIT_IDX  8'h80
`define CRL_IDX_MAX         8'hAF

// lock byte codes
`define CRL_LOCK_SET        8'hFF
`define CRL_LOCK_CLEAR      8'h00

// configuration word field: internal feedback resistor select
`define CRL_CFG_INT_RES_BIT 12

// calibration register selectors
`define CRL_SEL_CONFIG      3'h0
`define CRL_SEL_OFFSET_TC   3'h1
`define CRL_SEL_SPAN_TC     3'h2
`define CRL_SEL_OFFSET_LUT  3'h3
`define CRL_SEL_SPAN_LUT    3'h4
`define CRL_NUM_CAL         5

// reset values
`define CRL_CAL_RESET       16'h0000
`define CRL_IDX_RESET       8'h00

// timing
`define CRL_CLK_KHZ         10000
`define CRL_TICK_US         1000
`define CRL_TICK_CYCLES     ((`CRL_TICK_US * `CRL_CLK_KHZ) / 1000)

`endif

//--- inc/crl_pkg.sv
/*
 * Types shared by the calibration register loader modules.
 * Assumes crl_regs.svh supplies the widths.
 */
`include "crl_regs.svh"

package crl_pkg;
    typedef logic [15:0]             crl_word_t;
    typedef logic [7:0]              crl_byte_t;
    typedef logic [`CRL_ADDR_W-1:0]  crl_addr_t;
    typedef logic [`CRL_PAGE_W-1:0]  crl_page_t;
    typedef logic [2:0]              crl_sel_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOCK_RD,
        ST_LOCK_CHK,
        ST_ADDR_LO,
        ST_ADDR_HI,
        ST_STORE
    } crl_state_e;
endpackage

//--- inc/crl_mem_if.sv
/*
 * Carrier between the loader and its byte-wide calibration memory.
 * Assumes one clock; read data appears one edge after the address.
 */
`timescale 1ns/1ps

interface crl_mem_if;
    import crl_pkg::*;
    crl_addr_t rd_addr;   // read byte address
    crl_byte_t rd_data;   // registered read byte
    logic      wr_en;     // byte write strobe
    crl_addr_t wr_addr;   // write byte address
    crl_byte_t wr_data;   // write byte
    logic      erase_en;  // page erase strobe
    crl_page_t erase_pg;  // page to erase

    modport loader (output rd_addr, wr_en, wr_addr, wr_data, erase_en, erase_pg,
                    input  rd_data);
    modport mem    (input  rd_addr, wr_en, wr_addr, wr_data, erase_en, erase_pg,
                    output rd_data);
endinterface

//--- src/crl_eeprom.sv
/*
 * Byte-wide calibration memory, 768 x 8 in 12 pages of 64 bytes.
 * Assumes the loader gates writes and erases; erased bytes read FFh.
 */
`timescale 1ns/1ps
`include "crl_regs.svh"

module crl_eeprom
    import crl_pkg::*;
#(
    parameter int BYTES      = `CRL_MEM_BYTES,
    parameter int PAGE_BYTES = `CRL_PAGE_BYTES
) (
    input  wire logic clk_sys,   // system clock
    input  wire logic rst_n,     // async reset, active low
    crl_mem_if.mem    mem        // memory port
);
    crl_byte_t mem_array [BYTES];
    crl_byte_t rd_data_reg;
    crl_byte_t rd_data_next;

    always_comb begin
        rd_data_next = (int'(mem.rd_addr) < BYTES) ? mem_array[mem.rd_addr] : 8'hFF;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // one page erased on its own; other pages untouched
    always_ff @(posedge clk_sys) begin
        if (mem.erase_en) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                mem_array[int'(mem.erase_pg) * PAGE_BYTES + i] <= 8'hFF;
            end
        end else if (mem.wr_en && int'(mem.wr_addr) < BYTES) begin
            mem_array[mem.wr_addr] <= mem.wr_data;
        end
    end

    assign mem.rd_data = rd_data_reg;
endmodule // crl_eeprom

//--- src/crl_temp_index.sv
/*
 * Temperature index timer: samples the converter code once per period and clamps it.
 * Assumes temp_code comes from logic on the same clock.
 */
`timescale 1ns/1ps
`include "crl_regs.svh"

module crl_temp_index
    import crl_pkg::*;
#(
    parameter int TICK_CYCLES = `CRL_TICK_CYCLES
) (
    input  wire logic      clk_sys,    // system clock
    input  wire logic      rst_n,      // async reset, active low
    input  wire crl_byte_t temp_code,  // converter output
    output crl_byte_t      index,      // clamped temperature index
    output logic           tick        // one-cycle pulse at period end
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    crl_byte_t     index_reg;
    crl_byte_t     index_next;
    logic          tick_reg;
    logic          tick_next;

    always_comb begin
        cnt_next   = cnt_reg + CW'(1);
        index_next = index_reg;
        tick_next  = 1'b0;
        if (cnt_reg == CW'(TICK_CYCLES - 1)) begin
            cnt_next   = '0;
            tick_next  = 1'b1;
            // saturate above the last table entry, no wraparound
            index_next = (temp_code > `CRL_IDX_MAX) ? `CRL_IDX_MAX : temp_code;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg   <= '0;
            index_reg <= `CRL_IDX_RESET;
            tick_reg  <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            index_reg <= index_next;
            tick_reg  <= tick_next;
        end
    end

    assign index = index_reg;
    assign tick  = tick_reg;
endmodule // crl_temp_index

//--- src/crl_loader.sv
/*
 * Calibration register loader: fills five 16-bit calibration registers from the
 * byte-wide calibration memory when locked, or from serial loads when unlocked.
 * Assumes the serial command decoder drives the ser_* and mem_* strobes on clk_sys,
 * the converter code is on clk_sys, and unlock_pin is asynchronous.
 */
`timescale 1ns/1ps
`include "crl_regs.svh"

module crl_loader
    import crl_pkg::*;
#(
    parameter int TICK_CYCLES = `CRL_TICK_CYCLES
) (
    input  wire logic      clk_sys,         // system clock, 10 MHz
    input  wire logic      rst_n,           // async reset, active low
    input  wire logic      unlock_pin,      // asynchronous unlock pin, high unlocks
    input  wire crl_byte_t temp_code,       // temperature converter code
    input  wire logic      ser_ld_en,       // serial register load strobe
    input  wire crl_sel_t  ser_ld_sel,      // which calibration register
    input  wire crl_word_t ser_ld_data,     // serial load value
    input  wire logic      mem_wr_en,       // serial memory byte write strobe
    input  wire crl_addr_t mem_wr_addr,     // memory byte address
    input  wire crl_byte_t mem_wr_data,     // memory byte data
    input  wire logic      mem_erase_en,    // serial page erase strobe
    input  wire crl_page_t mem_erase_pg,    // page to erase
    output crl_word_t      configuration_q, // configuration register
    output crl_word_t      offset_tc_q,     // offset temperature coefficient register
    output crl_word_t      span_tc_q,       // span temperature coefficient register
    output crl_word_t      offset_lut_q,    // offset table register
    output crl_word_t      span_lut_q,      // span table register
    output logic           int_res_sel,     // high selects internal feedback resistors
    output crl_byte_t      temp_index_q,    // index used by the last load
    output logic           locked,          // lock in force
    output logic           load_busy        // memory load in progress
);
    crl_mem_if mem_bus ();

    crl_eeprom #(
        .BYTES      (`CRL_MEM_BYTES),
        .PAGE_BYTES (`CRL_PAGE_BYTES)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .mem     (mem_bus)
    );

    crl_byte_t idx_live;
    logic      tick;

    crl_temp_index #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tidx (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .temp_code (temp_code),
        .index     (idx_live),
        .tick      (tick)
    );

    // unlock pin synchroniser
    logic unlock_s1_reg;
    logic unlock_s2_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unlock_s1_reg <= 1'b0;
            unlock_s2_reg <= 1'b0;
        end else begin
            unlock_s1_reg <= unlock_pin;
            unlock_s2_reg <= unlock_s2_next_src(unlock_s1_reg);
        end
    end

    function automatic logic unlock_s2_next_src(input logic s1);
        return s1;
    endfunction

    // byte address of the low byte of word step for a given index
    function automatic crl_addr_t word_addr(input crl_sel_t sel, input crl_byte_t idx);
        crl_addr_t a;
        a = `CRL_ADDR_CONFIG;
        unique case (sel)
            `CRL_SEL_CONFIG:     a = `CRL_ADDR_CONFIG;
            `CRL_SEL_OFFSET_TC:  a = `CRL_ADDR_OFFSET_TC;
            `CRL_SEL_SPAN_TC:    a = `CRL_ADDR_SPAN_TC;
            `CRL_SEL_OFFSET_LUT: a = `CRL_OFFSET_LUT_BASE
                                     + {1'b0, idx, 1'b0};
            `CRL_SEL_SPAN_LUT: begin
                if (idx < `CRL_SPAN_SPLIT_IDX) begin
                    a = `CRL_SPAN_LUT_BASE + {1'b0, idx, 1'b0};
                end else begin
                    a = `CRL_SPAN_LUT_BASE2
                        + {1'b0, idx - `CRL_SPAN_SPLIT_IDX, 1'b0};
                end
            end
            default:             a = `CRL_ADDR_CONFIG;
        endcase
        return a;
    endfunction

    crl_state_e state_reg;
    crl_state_e state_next;
    crl_word_t  cal_reg  [`CRL_NUM_CAL];
    crl_word_t  cal_next [`CRL_NUM_CAL];
    crl_sel_t   step_reg;
    crl_sel_t   step_next;
    crl_addr_t  addr_reg;
    crl_addr_t  addr_next;
    crl_byte_t  lo_reg;
    crl_byte_t  lo_next;
    crl_byte_t  idx_reg;
    crl_byte_t  idx_next;
    crl_byte_t  lock_byte_reg;
    crl_byte_t  lock_byte_next;
    logic       pending_reg;
    logic       pending_next;
    logic       locked_reg;
    logic       locked_next;
    logic       busy_reg;
    logic       busy_next;
    logic       int_res_reg;
    logic       int_res_next;
    logic       start;

    assign start = (state_reg == ST_IDLE) && pending_reg;

    always_comb begin
        state_next     = state_reg;
        step_next      = step_reg;
        addr_next      = addr_reg;
        lo_next        = lo_reg;
        idx_next       = idx_reg;
        lock_byte_next = lock_byte_reg;
        for (int i = 0; i < `CRL_NUM_CAL; i++) begin
            cal_next[i] = cal_reg[i];
        end
        // tick during a load is kept, a new tick wins over the clear
        pending_next = (pending_reg && !start) || tick;
        locked_next  = (lock_byte_reg == `CRL_LOCK_SET) && !unlock_s2_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (pending_reg) begin
                    addr_next  = `CRL_ADDR_CONTROL;
                    idx_next   = idx_live;
                    state_next = ST_LOCK_RD;
                end
            end
            ST_LOCK_RD: begin
                state_next = ST_LOCK_CHK;
            end
            ST_LOCK_CHK: begin
                lock_byte_next = mem_bus.rd_data;
                // fixed and table words only while locked
                if (mem_bus.rd_data == `CRL_LOCK_SET && !unlock_s2_reg) begin
                    step_next  = `CRL_SEL_CONFIG;
                    addr_next  = word_addr(`CRL_SEL_CONFIG, idx_reg);
                    state_next = ST_ADDR_LO;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_ADDR_LO: begin
                addr_next  = addr_reg + 10'h001;
                state_next = ST_ADDR_HI;
            end
            ST_ADDR_HI: begin
                lo_next    = mem_bus.rd_data;
                state_next = ST_STORE;
            end
            ST_STORE: begin
                // whole word written at once after both bytes are in
                cal_next[step_reg] = {mem_bus.rd_data, lo_reg};
                if (step_reg == `CRL_SEL_SPAN_LUT) begin
                    state_next = ST_IDLE;
                end else begin
                    step_next  = step_reg + 3'h1;
                    addr_next  = word_addr(step_reg + 3'h1, idx_reg);
                    state_next = ST_ADDR_LO;
                end
            end
        endcase
        // serial loads accepted only when unlocked and no load runs
        if (ser_ld_en && !locked_reg && state_reg == ST_IDLE
            && int'(ser_ld_sel) < `CRL_NUM_CAL) begin
            cal_next[ser_ld_sel] = ser_ld_data;
        end
        int_res_next = cal_next[`CRL_SEL_CONFIG][`CRL_CFG_INT_RES_BIT];
        busy_next    = (state_next != ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            step_reg      <= `CRL_SEL_CONFIG;
            addr_reg      <= `CRL_ADDR_CONTROL;
            lo_reg        <= 8'h00;
            idx_reg       <= `CRL_IDX_RESET;
            lock_byte_reg <= `CRL_LOCK_CLEAR;
            pending_reg   <= 1'b1;
            locked_reg    <= 1'b0;
            busy_reg      <= 1'b0;
            int_res_reg   <= 1'b0;
            for (int i = 0; i < `CRL_NUM_CAL; i++) begin
                cal_reg[i] <= `CRL_CAL_RESET;
            end
        end else begin
            state_reg     <= state_next;
            step_reg      <= step_next;
            addr_reg      <= addr_next;
            lo_reg        <= lo_next;
            idx_reg       <= idx_next;
            lock_byte_reg <= lock_byte_next;
            pending_reg   <= pending_next;
            locked_reg    <= locked_next;
            busy_reg      <= busy_next;
            int_res_reg   <= int_res_next;
            for (int i = 0; i < `CRL_NUM_CAL; i++) begin
                cal_reg[i] <= cal_next[i];
            end
        end
    end

    // memory writes and erases come from the serial side only when unlocked
    assign mem_bus.rd_addr  = addr_reg;
    assign mem_bus.wr_en    = mem_wr_en && !locked_reg && !mem_erase_en;
    assign mem_bus.wr_addr  = mem_wr_addr;
    assign mem_bus.wr_data  = mem_wr_data;
    assign mem_bus.erase_en = mem_erase_en && !locked_reg
                              && int'(mem_erase_pg) < `CRL_PAGE_COUNT;
    assign mem_bus.erase_pg = mem_erase_pg;

    assign configuration_q = cal_reg[`CRL_SEL_CONFIG];
    assign offset_tc_q     = cal_reg[`CRL_SEL_OFFSET_TC];
    assign span_tc_q       = cal_reg[`CRL_SEL_SPAN_TC];
    assign offset_lut_q    = cal_reg[`CRL_SEL_OFFSET_LUT];
    assign span_lut_q      = cal_reg[`CRL_SEL_SPAN_LUT];
    assign int_res_sel     = int_res_reg;
    assign temp_index_q    = idx_reg;
    assign locked          = locked_reg;
    assign load_busy       = busy_reg;
endmodule // crl_loader

//--- dv/crl_ref_mem.sv
/* reference byte memory mirroring the bench's memory writes and page erases.
   assumes writes are only accepted while the unlock pin is high. */
`timescale 1ns/1ps
`include "crl_regs.svh"

module crl_ref_mem
    import crl_pkg::*;
(
    input wire logic      clk_sys,    // system clock
    input wire logic      unlock_pin, // writes accepted while high
    input wire logic      wr_en,      // byte write strobe
    input wire crl_addr_t wr_addr,    // byte address
    input wire crl_byte_t wr_data,    // byte data
    input wire logic      erase_en,   // page erase strobe
    input wire crl_page_t erase_pg    // page to erase
);
    crl_byte_t mem_q [`CRL_MEM_BYTES];

    always @(posedge clk_sys) begin
        if (unlock_pin && erase_en && erase_pg < `CRL_PAGE_COUNT) begin
            for (int i = 0; i < `CRL_PAGE_BYTES; i++) begin
                mem_q[erase_pg * `CRL_PAGE_BYTES + i] = 8'hFF;
            end
        end else if (unlock_pin && wr_en) begin
            mem_q[wr_addr] = wr_data;
        end
    end

    function automatic crl_word_t rd_word(input crl_addr_t a);
        return {mem_q[a + 10'h001], mem_q[a]};
    endfunction
endmodule // crl_ref_mem

//--- dv/crl_loader_assertions.sv
/* port-level timing checks of the calibration register loader.
   assumes it is bound onto crl_loader with the same TICK_CYCLES. */
`timescale 1ns/1ps
`include "crl_regs.svh"

module crl_loader_assertions
    import crl_pkg::*;
#(
    parameter int TICK_CYCLES = `CRL_TICK_CYCLES
) (
    input wire logic      clk_sys,         // system clock
    input wire logic      rst_n,           // async reset
    input wire logic      unlock_pin,      // unlock pin
    input wire logic      ser_ld_en,       // serial strobe
    input wire crl_sel_t  ser_ld_sel,      // serial target
    input wire crl_word_t ser_ld_data,     // serial value
    input wire crl_word_t configuration_q, // config register
    input wire crl_word_t offset_tc_q,     // offset tc register
    input wire crl_word_t span_tc_q,       // span tc register
    input wire crl_word_t offset_lut_q,    // offset table register
    input wire crl_word_t span_lut_q,      // span table register
    input wire logic      int_res_sel,     // resistor select
    input wire crl_byte_t temp_index_q,    // index of last load
    input wire logic      locked,          // lock in force
    input wire logic      load_busy        // load running
);
    logic [15:0] gap_reg;
    logic [15:0] gap_next;

    // idle cycles since the last load
    always_comb begin
        gap_next = (load_busy || gap_reg == 16'hFFFF) ? 16'h0000 : gap_reg + 16'h0001;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 16'h0000;
        end else begin
            gap_reg <= gap_next;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_load_ends: assert property ($rose(load_busy) |-> ##[2:20] !load_busy)
        else $error("load did not finish in time");
    a_load_period: assert property (gap_reg <= TICK_CYCLES)
        else $error("no load within one tick period");
    a_ser_config: assert property (ser_ld_en && !locked && !load_busy
        && ser_ld_sel == `CRL_SEL_CONFIG |=> configuration_q == $past(ser_ld_data))
        else $error("serial config load lost");
    a_ser_span: assert property (ser_ld_en && !locked && !load_busy
        && ser_ld_sel == `CRL_SEL_SPAN_LUT |=> span_lut_q == $past(ser_ld_data))
        else $error("serial span load lost");
    a_res_follow: assert property (int_res_sel == configuration_q[`CRL_CFG_INT_RES_BIT])
        else $error("resistor select differs from config bit");
    a_lock_refuse: assert property (locked && !load_busy && ser_ld_en
        |=> $stable({configuration_q, offset_tc_q, span_tc_q, offset_lut_q, span_lut_q}))
        else $error("serial load taken while locked");
    a_quiet_idle: assert property (!load_busy && !ser_ld_en
        |=> $stable({configuration_q, offset_tc_q, span_tc_q, offset_lut_q, span_lut_q}))
        else $error("register changed with no load");
    a_idx_clamp: assert property (temp_index_q <= `CRL_IDX_MAX)
        else $error("index beyond last entry");
    a_unlock_open: assert property (unlock_pin [*5] |-> !locked)
        else $error("locked while unlock pin high");
endmodule // crl_loader_assertions

bind crl_loader crl_loader_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .unlock_pin(unlock_pin), .ser_ld_en(ser_ld_en),
    .ser_ld_sel(ser_ld_sel), .ser_ld_data(ser_ld_data), .configuration_q(configuration_q),
    .offset_tc_q(offset_tc_q), .span_tc_q(span_tc_q), .offset_lut_q(offset_lut_q),
    .span_lut_q(span_lut_q), .int_res_sel(int_res_sel), .temp_index_q(temp_index_q),
    .locked(locked), .load_busy(load_busy));

//--- dv/test_crl_loader.sv
/* self-checking bench: serial loads, memory programming, locked refresh, page erase.
   assumes crl_ref_mem mirrors memory contents and the checker is bound. */
`timescale 1ns/1ps
`include "crl_regs.svh"

module test_crl_loader
    import crl_pkg::*;
;
    localparam int TICK = 50;
    logic      clk_sys, rst_n, unlock_pin, ser_ld_en, mem_wr_en, mem_erase_en;
    logic      int_res_sel, locked, load_busy;
    crl_byte_t temp_code, mem_wr_data, idx_q;
    crl_sel_t  ser_ld_sel;
    crl_addr_t mem_wr_addr;
    crl_page_t mem_erase_pg;
    crl_word_t ser_ld_data, cfg_q, otc_q, stc_q, olut_q, slut_q;
    crl_word_t exp_q [5];
    crl_byte_t idx_list [6] = '{8'h00, 8'h7F, 8'h80, 8'h85, 8'hAF, 8'hF0};
    int        errors, n_checks;

    crl_loader #(.TICK_CYCLES(TICK)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .unlock_pin(unlock_pin), .temp_code(temp_code), .ser_ld_en(ser_ld_en),
        .ser_ld_sel(ser_ld_sel), .ser_ld_data(ser_ld_data), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_erase_en(mem_erase_en),
        .mem_erase_pg(mem_erase_pg), .configuration_q(cfg_q), .offset_tc_q(otc_q),
        .span_tc_q(stc_q), .offset_lut_q(olut_q), .span_lut_q(slut_q),
        .int_res_sel(int_res_sel), .temp_index_q(idx_q), .locked(locked),
        .load_busy(load_busy));
    crl_ref_mem u_ref (.clk_sys(clk_sys), .unlock_pin(unlock_pin), .wr_en(mem_wr_en),
        .wr_addr(mem_wr_addr), .wr_data(mem_wr_data), .erase_en(mem_erase_en),
        .erase_pg(mem_erase_pg));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic crl_addr_t off_addr(input crl_byte_t c);
        return `CRL_OFFSET_LUT_BASE + {1'b0, c, 1'b0};
    endfunction
    function automatic crl_addr_t span_addr(input crl_byte_t c);
        if (c < `CRL_SPAN_SPLIT_IDX) begin
            return `CRL_SPAN_LUT_BASE + {1'b0, c, 1'b0};
        end
        return `CRL_SPAN_LUT_BASE2 + {1'b0, c - `CRL_SPAN_SPLIT_IDX, 1'b0};
    endfunction

    task automatic chk_word(input crl_word_t got, input crl_word_t exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic chk_regs;
        chk_word(cfg_q, exp_q[0]);
        chk_word(otc_q, exp_q[1]);
        chk_word(stc_q, exp_q[2]);
        chk_word(olut_q, exp_q[3]);
        chk_word(slut_q, exp_q[4]);
        chk_bit(int_res_sel, exp_q[0][`CRL_CFG_INT_RES_BIT]);
    endtask

    // waits for n complete loads, then settles at the falling edge
    task automatic wait_load(input int n);
        int i;
        repeat (n) begin
            for (i = 0; i < 500 && load_busy !== 1'b1; i++) @(posedge clk_sys);
            for (i = i; i < 500 && load_busy !== 1'b0; i++) @(posedge clk_sys);
            if (i >= 500) begin
                errors++;
                $display("[ERR] %0t load never finished", $time);
            end
        end
        @(negedge clk_sys);
    endtask
    task automatic ser_load(input crl_sel_t s, input crl_word_t d);
        @(posedge clk_sys);
        ser_ld_en   <= 1'b1;
        ser_ld_sel  <= s;
        ser_ld_data <= d;
        @(posedge clk_sys);
        ser_ld_en   <= 1'b0;
    endtask
    task automatic mem_wr(input crl_addr_t a, input crl_byte_t d);
        @(posedge clk_sys);
        mem_wr_en   <= 1'b1;
        mem_wr_addr <= a;
        mem_wr_data <= d;
        @(posedge clk_sys);
        mem_wr_en   <= 1'b0;
    endtask
    task automatic wr_word(input crl_addr_t a, input crl_word_t w);
        mem_wr(a, w[7:0]);
        mem_wr(a + 10'h001, w[15:8]);
    endtask

    task automatic t_program;
        wr_word(`CRL_ADDR_CONFIG, 16'h1A5C);
        wr_word(`CRL_ADDR_OFFSET_TC, 16'hFFFF);
        wr_word(`CRL_ADDR_SPAN_TC, 16'h0000);
        wr_word(`CRL_ADDR_CONTROL, {8'h00, `CRL_LOCK_SET});
        foreach (idx_list[k]) begin
            wr_word(off_addr(idx_list[k]), 16'hA500 ^ {6'h00, off_addr(idx_list[k])});
            wr_word(span_addr(idx_list[k]), 16'h5A00 ^ {6'h00, span_addr(idx_list[k])});
        end
        // unlocked: loads refused, registers still at reset
        @(negedge clk_sys);
        chk_regs();
        chk_bit(locked, 1'b0);
    endtask
    task automatic t_serial;
        crl_word_t v [5] = '{16'h1000, 16'hFFFF, 16'h0000, 16'h8001, 16'h7FFE};
        wait_load(1);
        for (int s = 0; s < 5; s++) begin
            ser_load(crl_sel_t'(s), v[s]);
            exp_q[s] = v[s];
        end
        ser_load(3'h5, 16'h5555);
        @(negedge clk_sys);
        chk_regs();
        ser_load(`CRL_SEL_CONFIG, 16'hEFFF);
        exp_q[0] = 16'hEFFF;
        wait_load(2);
        chk_regs();
    endtask
    task automatic t_locked;
        crl_byte_t c;
        @(posedge clk_sys);
        unlock_pin <= 1'b0;
        foreach (idx_list[k]) begin
            c = (idx_list[k] > `CRL_IDX_MAX) ? `CRL_IDX_MAX : idx_list[k];
            @(posedge clk_sys);
            temp_code <= idx_list[k];
            wait_load(3);
            exp_q[0] = u_ref.rd_word(`CRL_ADDR_CONFIG);
            exp_q[1] = u_ref.rd_word(`CRL_ADDR_OFFSET_TC);
            exp_q[2] = u_ref.rd_word(`CRL_ADDR_SPAN_TC);
            exp_q[3] = u_ref.rd_word(off_addr(c));
            exp_q[4] = u_ref.rd_word(span_addr(c));
            chk_regs();
            chk_word({8'h00, idx_q}, {8'h00, c});
            chk_bit(locked, 1'b1);
        end
    endtask
    task automatic t_lock_refuse;
        ser_load(`CRL_SEL_OFFSET_TC, 16'h1234);
        mem_wr(`CRL_ADDR_CONTROL, `CRL_LOCK_CLEAR);
        @(negedge clk_sys);
        chk_regs();
        wait_load(2);
        chk_bit(locked, 1'b1);
    endtask
    task automatic t_erase;
        @(posedge clk_sys);
        unlock_pin <= 1'b1;
        temp_code  <= 8'h00;
        wait_load(2);
        @(posedge clk_sys);
        mem_erase_en <= 1'b1;
        mem_erase_pg <= 4'h0;
        @(posedge clk_sys);
        mem_erase_en <= 1'b0;
        unlock_pin   <= 1'b0;
        wait_load(3);
        exp_q[3] = u_ref.rd_word(off_addr(8'h00));
        exp_q[4] = u_ref.rd_word(span_addr(8'h00));
        chk_regs();
    endtask

    // mid-run reset while locked: power-on load with index zero
    task automatic t_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk_word(cfg_q, `CRL_CAL_RESET);
        wait_load(1);
        exp_q[3] = u_ref.rd_word(off_addr(8'h00));
        exp_q[4] = u_ref.rd_word(span_addr(8'h00));
        chk_regs();
        chk_word({8'h00, idx_q}, 16'h0000);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        unlock_pin = 1'b1;
        temp_code = 8'h00;
        ser_ld_en = 1'b0;
        ser_ld_sel = 3'h0;
        ser_ld_data = 16'h0000;
        mem_wr_en = 1'b0;
        mem_wr_addr = 10'h000;
        mem_wr_data = 8'h00;
        mem_erase_en = 1'b0;
        mem_erase_pg = 4'h0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        for (int s = 0; s < 5; s++) exp_q[s] = `CRL_CAL_RESET;
        chk_regs();
        t_program();
        t_serial();
        t_locked();
        t_lock_refuse();
        t_reset();
        t_erase();
        test_done();
    end
endmodule // test_crl_loader
